// ### ext_bus_pkg.sv
/*
 * Constants, types and address decoding values of the external bus unit.
 * Assumes word addressing on the external bus (one address per 32 bits).
 */
// What this block does
// RULE1 - Master reads drive the read strobe low, except SDRAM reads.
// RULE2 - As slave, a low read strobe marks a read of internal space.
// RULE3 - Low write strobe on even words and on every 32-bit bus write.
// RULE4 - High write strobe on long words or odd words over 64-bit bus.
// RULE5 - External masters use high strobe for high word, low for low.
// RULE6 - Strobes and selects change on the same edge as the address.
// RULE7 - Slaves may hold acknowledge low; the master waits for it.
// RULE8 - As slave, the device holds acknowledge low to insert waits.
// RULE9 - Bank select 0 for top bits 00110, bank select 1 for 00111.
// RULE10 - Host space select whenever address bit 31 is one.
// RULE11 - Burst marks consecutive addresses; slaves may count internally.
// RULE12 - During host bursts in, the device increments the address itself.
// RULE13 - Boot select is the boot memory chip select and a reset strap.
// RULE14 - Identity from three pins; identity zero initialises SDRAM.
// RULE15 - Transfers are word, long or quad sized.
// RULE16 - Addresses are aligned to the transfer size.
// RULE17 - Narrow buses split a transfer into consecutive bus cycles.
// RULE18 - Writes complete for the requester once the outbound queue holds them.
// RULE19 - Read data is captured inbound and sent to the original target.
// RULE20 - Slave data enters the inbound queue with address and attributes.
// RULE21 - Width of 32 or 64 bits set apart for memory, multiprocessor, host.
// RULE22 - Boot memory uses an 8-bit bus with fixed wait cycles.
package ext_bus_pkg;

    localparam logic [1:0] SIZE_WORD = 2'h0;
    localparam logic [1:0] SIZE_LONG = 2'h1;
    localparam logic [1:0] SIZE_QUAD = 2'h2;

    localparam logic [4:0] BANK0_SEL = 5'h06;
    localparam logic [4:0] BANK1_SEL = 5'h07;
    localparam logic [4:0] BOOT_SEL = 5'h04;
    localparam logic [4:0] SDRAM_SEL = 5'h08;
    localparam logic [4:0] MP_SEL = 5'h02;

    localparam logic [3:0] BOOT_WAIT_CYCLES = 4'h3;

    typedef enum logic [1:0] {
        M_IDLE = 2'b00,
        M_BEAT = 2'b01,
        M_PUSH = 2'b10
    } mst_state_t;

    typedef struct packed {
        logic write;
        logic [1:0] size;
        logic [31:0] addr;
        logic [127:0] data;
        logic [3:0] tag;
    } req_t;

    typedef struct packed {
        logic from_slave;
        logic [1:0] attr;
        logic [31:0] addr;
        logic [3:0] tag;
        logic [127:0] data;
    } inb_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [63:0] data;
        logic rd_n;
        logic wrl_n;
        logic wrh_n;
        logic [1:0] ms_n;
        logic msh_n;
        logic bms_n;
        logic burst;
    } pins_t;

endpackage

// ### external_bus_unit.sv
/*
 * External bus unit: master engine with outbound and inbound queues and
 * the slave responder for external masters reaching internal space.
 * Assumes bus mastership is granted by outside arbitration.
 */
`timescale 1ns/100ps
module external_bus_unit import ext_bus_pkg::*; (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic req_valid_in,
    input wire req_t req_in,
    output logic req_ready_out,
    output logic misalign_err_out,
    output logic inb_valid_out,
    output inb_t inb_out,
    input wire logic inb_ready_in,
    output logic slv_rd_req_out,
    output logic [31:0] slv_rd_addr_out,
    input wire logic slv_rd_valid_in,
    input wire logic [63:0] slv_rd_data_in,
    input wire logic width_mem64_in,
    input wire logic width_mp64_in,
    input wire logic width_host64_in,
    input wire logic bus_grant_in,
    input wire logic [2:0] id_in,
    input wire logic [31:0] ext_address_bus_in,
    output logic [31:0] ext_address_bus_out,
    input wire logic [63:0] ext_data_bus_in,
    output logic [63:0] ext_data_bus_out,
    output logic ext_data_bus_oe_b_out,
    input wire logic read_strobe_n_in,
    output logic read_strobe_n_out,
    input wire logic write_low_strobe_n_in,
    output logic write_low_strobe_n_out,
    input wire logic write_high_strobe_n_in,
    output logic write_high_strobe_n_out,
    input wire logic burst_indicator_in,
    output logic burst_indicator_out,
    output logic [1:0] bank_select_n_out,
    output logic host_space_select_n_out,
    input wire logic boot_memory_select_n_in,
    output logic boot_memory_select_n_out,
    output logic master_oe_b_out,
    input wire logic ack_in,
    output logic ack_out,
    output logic ack_oe_b_out,
    output logic rom_boot_mode_out,
    output logic sdram_init_master_out
);
    ////////////////////////////////////////////////////////////////////////
    // Decoding functions.
    function automatic logic [4:0] nbeats(input logic [1:0] size,
                                          input logic w64,
                                          input logic boot);
        logic [4:0] n;
        n = 5'h01;
        if (boot) begin
            n = 5'h04 << size;
        end else if (size == SIZE_LONG) begin
            n = w64 ? 5'h01 : 5'h02;
        end else if (size == SIZE_QUAD) begin
            n = w64 ? 5'h02 : 5'h04;
        end
        return n;
    endfunction
    function automatic logic space_w64(input logic [31:0] a,
        input logic [2:0] wd); // RULE21
        logic w;
        w = wd[0];
        if (a[31]) begin
            w = wd[2];
        end else if (a[31:28] == 4'h3 || a[31:27] == BOOT_SEL ||
                     a[31:27] == SDRAM_SEL) begin
            w = wd[1];
        end
        return w;
    endfunction
    function automatic pins_t beat_pins(input req_t r, input logic [4:0] b,
                                        input logic w64, input logic boot);
        pins_t p;
        logic wide;
        wide = w64 && !boot && r.size != SIZE_WORD;
        p.addr = r.addr + (wide ? {26'h0, b, 1'b0} : {27'h0, b}); // RULE17
        if (boot) begin
            p.data = {56'h0, r.data[8*b +: 8]}; // RULE22
        end else if (!w64) begin
            p.data = {32'h0, r.data[32*b +: 32]};
        end else if (r.size == SIZE_WORD) begin
            p.data = r.addr[0] ? {r.data[31:0], 32'h0} : {32'h0, r.data[31:0]};
        end else begin
            p.data = r.data[64*b +: 64];
        end
        p.rd_n = r.write || r.addr[31:27] == SDRAM_SEL; // RULE1
        p.wrl_n = !(r.write && (boot || !w64 || r.size != SIZE_WORD ||
                                !r.addr[0])); // RULE3
        p.wrh_n = !(r.write && !boot && w64 &&
                    (r.size != SIZE_WORD || r.addr[0])); // RULE4
        p.ms_n[0] = p.addr[31:27] != BANK0_SEL; // RULE9
        p.ms_n[1] = p.addr[31:27] != BANK1_SEL; // RULE9
        p.msh_n = !p.addr[31]; // RULE10
        p.bms_n = !boot; // RULE13
        p.burst = nbeats(r.size, w64, boot) != 5'h01; // RULE11
        return p;
    endfunction
    ////////////////////////////////////////////////////////////////////////
    // Outbound queue and master engine.
    req_t ob_q;
    logic ob_valid_q, ready_q, err_q;
    mst_state_t state_q, state_d;
    pins_t pins_q, pins_d;
    logic drv_q, w64_q, boot_q;
    logic [4:0] beat_q, beats_q;
    logic [3:0] wait_q;
    logic [127:0] rbuf_q;
    inb_t inb_q;
    logic inb_valid_q;
    wire accept = req_valid_in && ready_q;
    wire misaligned = (req_in.size == SIZE_LONG && req_in.addr[0]) ||
                      (req_in.size == SIZE_QUAD && req_in.addr[1:0] != 2'h0);
    wire ob_boot = ob_q.addr[31:27] == BOOT_SEL;
    wire ob_w64 = space_w64(ob_q.addr,
        {width_host64_in, width_mem64_in, width_mp64_in});
    wire start = state_q == M_IDLE && ob_valid_q && bus_grant_in;
    wire beat_done = state_q == M_BEAT && wait_q == 4'h0 && ack_in; // RULE7
    wire last_beat = beat_q + 5'h01 == beats_q;
    wire slv_cap;
    wire push = state_q == M_PUSH && !inb_valid_q && !slv_cap;
    wire ob_done = (beat_done && last_beat && ob_q.write) || push;
    wire ob_valid_d = accept ? !misaligned : ob_valid_q && !ob_done; // RULE16
    always_comb begin
        state_d = state_q;
        case (state_q)
            M_IDLE: if (start) state_d = M_BEAT;
            M_BEAT: if (beat_done && last_beat) begin
                state_d = ob_q.write ? M_IDLE : M_PUSH;
            end
            M_PUSH: if (push) state_d = M_IDLE;
            default: state_d = M_IDLE;
        endcase
    end
    always_comb begin
        pins_d = pins_q;
        if (start) begin
            pins_d = beat_pins(ob_q, 5'h00, ob_w64, ob_boot); // RULE6
        end else if (beat_done && !last_beat) begin
            pins_d = beat_pins(ob_q, beat_q + 5'h01, w64_q, boot_q); // RULE6
        end else if (beat_done) begin
            pins_d.rd_n = 1'b1;
            pins_d.wrl_n = 1'b1;
            pins_d.wrh_n = 1'b1;
            pins_d.ms_n = 2'h3;
            pins_d.msh_n = 1'b1;
            pins_d.bms_n = 1'b1;
            pins_d.burst = 1'b0;
        end
    end
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ob_q <= '0;
            ob_valid_q <= 1'b0;
            ready_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            if (accept) ob_q <= req_in; // RULE18
            ob_valid_q <= ob_valid_d;
            ready_q <= !ob_valid_d;
            err_q <= accept && misaligned; // RULE16
        end
    end
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q <= M_IDLE;
            pins_q <= '{addr: 32'h0, data: 64'h0, rd_n: 1'b1, wrl_n: 1'b1,
                        wrh_n: 1'b1, ms_n: 2'h3, msh_n: 1'b1, bms_n: 1'b1,
                        burst: 1'b0};
            drv_q <= 1'b0;
            w64_q <= 1'b0;
            boot_q <= 1'b0;
            beat_q <= 5'h00;
            beats_q <= 5'h01;
            wait_q <= 4'h0;
        end else begin
            state_q <= state_d;
            pins_q <= pins_d;
            drv_q <= state_d == M_BEAT;
            if (start) begin
                w64_q <= ob_w64;
                boot_q <= ob_boot;
                beat_q <= 5'h00;
                beats_q <= nbeats(ob_q.size, ob_w64, ob_boot); // RULE15
                wait_q <= ob_boot ? BOOT_WAIT_CYCLES : 4'h0; // RULE22
            end else if (beat_done) begin
                beat_q <= beat_q + 5'h01;
                wait_q <= boot_q ? BOOT_WAIT_CYCLES : 4'h0;
            end else if (wait_q != 4'h0) begin
                wait_q <= wait_q - 4'h1;
            end
        end
    end
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rbuf_q <= 128'h0;
        end else if (beat_done && !ob_q.write) begin
            if (boot_q) begin
                rbuf_q[8*beat_q +: 8] <= ext_data_bus_in[7:0];
            end else if (!w64_q) begin
                rbuf_q[32*beat_q +: 32] <= ext_data_bus_in[31:0];
            end else if (ob_q.size == SIZE_WORD) begin
                rbuf_q[31:0] <= ob_q.addr[0] ? ext_data_bus_in[63:32] :
                                               ext_data_bus_in[31:0];
            end else begin
                rbuf_q[64*beat_q +: 64] <= ext_data_bus_in;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Slave responder.
    logic [31:0] slv_addr_q;
    logic slv_burst_q, slv_have_q, slv_pend_q, ack_q, ack_oe_b_q;
    logic [63:0] slv_data_q;
    logic rd_req_q;
    logic [31:0] rd_addr_q;
    wire slv_step2 = width_mp64_in;
    wire [31:0] slv_eff = (burst_indicator_in && slv_burst_q) ?
                          slv_addr_q : ext_address_bus_in; // RULE12
    wire slv_own = slv_eff[31:27] == MP_SEL && slv_eff[26:24] == id_in;
    wire slv_rd = !drv_q && !read_strobe_n_in && slv_own; // RULE2
    wire slv_wr = !drv_q && slv_own &&
                  (!write_low_strobe_n_in || !write_high_strobe_n_in); // RULE5
    assign slv_cap = slv_wr && ack_q; // RULE20
    wire slv_rd_done = slv_rd && slv_have_q;
    wire slv_done = slv_cap || slv_rd_done;
    wire rd_issue = slv_rd && !slv_have_q && !slv_pend_q;
    wire slv_have_d = slv_rd_valid_in || (slv_have_q && !slv_rd_done);
    wire inb_valid_d = (inb_valid_q && !inb_ready_in) || push || slv_cap;
    wire ack_d = slv_rd ? slv_have_d :
                 !inb_valid_d && state_d != M_PUSH; // RULE8
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            slv_addr_q <= 32'h0;
            slv_burst_q <= 1'b0;
            slv_have_q <= 1'b0;
            slv_pend_q <= 1'b0;
            slv_data_q <= 64'h0;
            ack_q <= 1'b0;
            ack_oe_b_q <= 1'b1;
            rd_req_q <= 1'b0;
            rd_addr_q <= 32'h0;
        end else begin
            if (slv_done) begin
                slv_addr_q <= slv_eff + (slv_step2 ? 32'h2 : 32'h1); // RULE12
                slv_burst_q <= burst_indicator_in; // RULE11
            end
            slv_have_q <= slv_have_d;
            slv_pend_q <= rd_issue || (slv_pend_q && !slv_rd_valid_in);
            if (slv_rd_valid_in) slv_data_q <= slv_rd_data_in;
            ack_q <= ack_d;
            ack_oe_b_q <= !(slv_rd || slv_wr);
            rd_req_q <= rd_issue;
            if (rd_issue) rd_addr_q <= slv_eff;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Inbound queue, strap and identity.
    logic rom_boot_q, strap_taken_q, sdram_init_q;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            inb_q <= '0;
            inb_valid_q <= 1'b0;
        end else begin
            inb_valid_q <= inb_valid_d;
            if (push) begin
                inb_q <= '{from_slave: 1'b0, attr: ob_q.size,
                           addr: ob_q.addr, tag: ob_q.tag,
                           data: rbuf_q}; // RULE19
            end else if (slv_cap) begin
                inb_q <= '{from_slave: 1'b1,
                           attr: {!write_high_strobe_n_in,
                                  !write_low_strobe_n_in},
                           addr: slv_eff, tag: 4'h0,
                           data: {64'h0, ext_data_bus_in}}; // RULE20
            end
        end
    end
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rom_boot_q <= 1'b0;
            strap_taken_q <= 1'b0;
            sdram_init_q <= 1'b0;
        end else begin
            if (!strap_taken_q) rom_boot_q <= boot_memory_select_n_in; // RULE13
            strap_taken_q <= 1'b1;
            sdram_init_q <= id_in == 3'h0; // RULE14
        end
    end
    assign req_ready_out = ready_q;
    assign misalign_err_out = err_q;
    assign inb_valid_out = inb_valid_q;
    assign inb_out = inb_q;
    assign slv_rd_req_out = rd_req_q;
    assign slv_rd_addr_out = rd_addr_q;
    assign ext_address_bus_out = pins_q.addr;
    assign ext_data_bus_out = drv_q ? pins_q.data : slv_data_q;
    assign ext_data_bus_oe_b_out = !((drv_q && ob_q.write) || slv_have_q);
    assign read_strobe_n_out = pins_q.rd_n;
    assign write_low_strobe_n_out = pins_q.wrl_n;
    assign write_high_strobe_n_out = pins_q.wrh_n;
    assign burst_indicator_out = pins_q.burst;
    assign bank_select_n_out = pins_q.ms_n;
    assign host_space_select_n_out = pins_q.msh_n;
    assign boot_memory_select_n_out = pins_q.bms_n;
    assign master_oe_b_out = !drv_q;
    assign ack_out = ack_q;
    assign ack_oe_b_out = ack_oe_b_q;
    assign rom_boot_mode_out = rom_boot_q;
    assign sdram_init_master_out = sdram_init_q;
    ////////////////////////////////////////////////////////////////////////
    // Assertions.
    a_bank_decode: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        drv_q |-> (!pins_q.ms_n[0] == (pins_q.addr[31:27] == BANK0_SEL)) &&
        (!pins_q.ms_n[1] == (pins_q.addr[31:27] == BANK1_SEL))) // RULE9
        else $error("Bank select does not match address.");
    a_host_decode: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        drv_q |-> pins_q.msh_n == !pins_q.addr[31]) // RULE10
        else $error("Host select does not match address bit 31.");
    a_read_strobe: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        drv_q && !ob_q.write && ob_q.addr[31:27] != SDRAM_SEL
        |-> !pins_q.rd_n && pins_q.wrl_n) // RULE1
        else $error("Read strobe missing on master read.");
    a_low_strobe: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        drv_q && ob_q.write && !w64_q |-> !pins_q.wrl_n && pins_q.wrh_n)
        // RULE3
        else $error("Narrow bus write strobes wrong.");
    a_high_strobe: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        drv_q && ob_q.write && w64_q && !boot_q && ob_q.size != SIZE_WORD
        |-> !pins_q.wrh_n && !pins_q.wrl_n) // RULE4
        else $error("Long write missing high strobe.");
    a_beat_split: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        start && !ob_boot && !ob_w64 && ob_q.size == SIZE_QUAD
        |=> beats_q == 5'h04 && pins_q.burst) // RULE17
        else $error("Quad on narrow bus not split in four.");
    a_burst_count: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        slv_done && burst_indicator_in && !slv_step2
        |=> slv_addr_q == $past(slv_eff) + 32'h1) // RULE12
        else $error("Slave burst address not incremented.");
    a_slave_wait: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        rd_issue |=> !ack_q [*1] ##0 slv_pend_q) // RULE8
        else $error("Acknowledge given before slave read data.");
    a_queue_take: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        accept && !misaligned |=> ob_valid_q && !req_ready_out) // RULE18
        else $error("Outbound queue did not capture request.");
    a_inbound_hold: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        inb_valid_q && !inb_ready_in |=> inb_valid_q && $stable(inb_q))
        // RULE19
        else $error("Inbound entry lost before it was taken.");
    a_boot_wait: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        start && ob_boot |=> !beat_done [*3]) // RULE22
        else $error("Boot beat ended before fixed wait cycles.");
    a_id_zero: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        id_in == 3'h0 |=> sdram_init_master_out) // RULE14
        else $error("Identity zero not flagged as SDRAM initialiser.");
endmodule // external_bus_unit

// ### slave_model.sv
/* Far-side slave for the unit's master beats; holds acknowledge low for wait_in cycles of each beat.
 * Assumes the unit under test masters the bus while this answers. */
`timescale 1ns/100ps
module slave_model import ext_bus_pkg::*; (
    input wire logic clk_in,
    input wire logic [3:0] wait_in,
    input wire pins_t pins_in,
    input wire logic oe_b_in,
    output logic ack_out,
    output logic [63:0] rdata_out,
    output logic [15:0] beats_out,
    output pins_t last_out
);
logic [3:0] wcnt_q = 4'h0;
logic [63:0] junk_q = 64'h0;
initial beats_out = 16'h0;
// Acknowledge stays low for the wait count of every beat.
assign ack_out = oe_b_in | (wcnt_q >= wait_in);
wire done = !oe_b_in && ack_out &&
    (pins_in.bms_n || wcnt_q >= BOOT_WAIT_CYCLES);
// Released data lines show a changing pattern, not the last value.
assign rdata_out = pins_in.rd_n ? junk_q : {~pins_in.addr, pins_in.addr};
always @(posedge clk_in) begin
    junk_q <= ~rdata_out;
    wcnt_q <= (oe_b_in || done) ? 4'h0 : wcnt_q + 4'h1;
    if (done) begin
        beats_out <= beats_out + 16'h1;
        last_out <= pins_in;
    end
end
endmodule // slave_model

// ### tb.sv
/* Testbench: master transfers, directed and random, and an outside
 * master reaching internal space. Assumes the slave model on the bus. */
`timescale 1ns/100ps
module tb import ext_bus_pkg::*;;
logic clk_in = 1'b0;
logic rst_b_in, req_valid_in, inb_ready_in, slv_rd_valid_in, ack_in;
logic bus_grant_in, width_mem64_in, width_mp64_in, width_host64_in;
logic read_strobe_n_in, write_low_strobe_n_in, write_high_strobe_n_in;
logic burst_indicator_in, boot_memory_select_n_in, req_ready_out;
logic misalign_err_out, inb_valid_out, slv_rd_req_out, master_oe_b_out;
logic ext_data_bus_oe_b_out, read_strobe_n_out, write_low_strobe_n_out;
logic write_high_strobe_n_out, burst_indicator_out, ack_out, ack_oe_b_out;
logic host_space_select_n_out, boot_memory_select_n_out, rom_boot_mode_out;
logic sdram_init_master_out;
logic [1:0] bank_select_n_out;
logic [2:0] id_in;
logic [3:0] wt;
logic [15:0] beats;
logic [31:0] ext_address_bus_in, ext_address_bus_out, slv_rd_addr_out, xa, r;
logic [63:0] ext_data_bus_in, ext_data_bus_out, slv_rd_data_in, xd, pd;
logic [31:0] base [4] = '{32'h3000_0000, 32'h3800_0000, 32'h8000_0000,
    32'h1100_0000};
req_t req_in;
inb_t inb_out;
pins_t pins, last;
inb_t inbq[$];
int error_cnt = 0;
int n_tests = 0;
int seed = 11;
int errs = 0;
always #50 clk_in = ~clk_in;
assign pins = '{ext_address_bus_out, ext_data_bus_out, read_strobe_n_out,
    write_low_strobe_n_out, write_high_strobe_n_out, bank_select_n_out,
    host_space_select_n_out, boot_memory_select_n_out, burst_indicator_out};
assign ext_address_bus_in = master_oe_b_out ? xa : ext_address_bus_out;
assign ext_data_bus_in = master_oe_b_out ? xd : pd;
external_bus_unit dut (.clk_in, .rst_b_in, .req_valid_in, .req_in,
    .req_ready_out, .misalign_err_out, .inb_valid_out, .inb_out,
    .inb_ready_in, .slv_rd_req_out, .slv_rd_addr_out, .slv_rd_valid_in,
    .slv_rd_data_in, .width_mem64_in, .width_mp64_in, .width_host64_in,
    .bus_grant_in, .id_in, .ext_address_bus_in, .ext_address_bus_out,
    .ext_data_bus_in, .ext_data_bus_out, .ext_data_bus_oe_b_out,
    .read_strobe_n_in, .read_strobe_n_out, .write_low_strobe_n_in,
    .write_low_strobe_n_out, .write_high_strobe_n_in,
    .write_high_strobe_n_out, .burst_indicator_in, .burst_indicator_out,
    .bank_select_n_out, .host_space_select_n_out, .boot_memory_select_n_in,
    .boot_memory_select_n_out, .master_oe_b_out, .ack_in, .ack_out,
    .ack_oe_b_out, .rom_boot_mode_out, .sdram_init_master_out);
slave_model sm (.clk_in, .wait_in(wt), .pins_in(pins),
    .oe_b_in(master_oe_b_out), .ack_out(ack_in), .rdata_out(pd),
    .beats_out(beats), .last_out(last));
always @(posedge clk_in) begin
    if (inb_valid_out === 1'b1 && inb_ready_in === 1'b1) inbq.push_back(inb_out);
    if (misalign_err_out === 1'b1) errs++;
end
////////////////////////////////////////////////////////////////////////////
task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
        $display("Regression OK");
    end else begin
        $display("Regression broken");
    end
    $finish;
endtask
task automatic cmp(input string n, input logic [127:0] e, input logic [127:0] g);
    n_tests++;
    if (g !== e) begin
        error_cnt++;
        $display("wrong value %s expected %h seen %h", n, e, g);
    end
endtask
task automatic to_chk(input logic bad, input string n);
    if (bad) begin
        error_cnt++;
        $display("wrong value %s expected 1 seen 0", n);
        print_verdict();
    end
endtask
function automatic logic w64_of(logic [31:0] a);
    if (a[31]) return width_host64_in;
    if (a[31:28] == 4'h3 || a[31:27] == SDRAM_SEL) return width_mem64_in;
    return width_mp64_in;
endfunction
function automatic logic [127:0] rd_exp(logic [31:0] a, logic w);
    logic [127:0] v;
    logic [31:0] b;
    v = '0;
    for (int i = 0; i < 4; i++) begin
        b = w ? a + 32'(i - i % 2) : a + 32'(i);
        v[32*i +: 32] = (w && (i % 2 == 1 || a[0])) ? ~b : b;
    end
    return v;
endfunction
task automatic pop(input logic [31:0] a, input logic [127:0] d,
        input logic [127:0] m, input logic fs);
    inb_t e;
    @(negedge clk_in);
    if (inbq.size() == 0) begin
        cmp("inbound entry", 1, 0);
    end else begin
        e = inbq.pop_front();
        cmp("inbound addr", {fs, a}, {e.from_slave, e.addr});
        cmp("inbound data", d, e.data & m);
    end
endtask
task automatic mop(input logic w, input logic [1:0] sz, input logic [31:0] a,
        input logic [15:0] nb);
    logic [15:0] b0;
    logic [127:0] m;
    logic [31:0] ea;
    logic [2:0] es;
    logic v;
    int k;
    b0 = beats;
    v = w64_of(a) && a[31:27] != BOOT_SEL;
    m = (128'h1 << (32 << sz)) - 128'h1;
    ea = a + 32'(nb - 16'h1) * ((v && sz != SIZE_WORD) ? 32'h2 : 32'h1);
    es = {w | (a[31:27] == SDRAM_SEL), !w | (v & sz == SIZE_WORD & a[0]),
        !w | !v | (sz == SIZE_WORD & !a[0])};
    inbq.delete();
    @(negedge clk_in);
    wt = 4'($random(seed) & 3);
    req_valid_in = 1'b1;
    req_in = '{w, sz, a, {4{~a}}, 4'h9};
    @(posedge clk_in);
    @(negedge clk_in);
    req_valid_in = 1'b0;
    k = 0;
    @(negedge clk_in);
    while (req_ready_out !== 1'b1 && k < 300) begin
        @(negedge clk_in);
        k++;
    end
    to_chk(k >= 300, "ready");
    cmp("beats", nb, beats - b0);
    if (nb != 0) begin
        cmp("last addr", ea, last.addr);
        cmp("selects", {a[31:27] != BANK1_SEL, a[31:27] != BANK0_SEL, ~a[31], a[31:27] != BOOT_SEL}, {last.ms_n, last.msh_n, last.bms_n});
        cmp("strobes", {es, nb > 1}, {last.rd_n, last.wrl_n, last.wrh_n, last.burst});
    end
    if (!w && nb != 0 && a[31:27] != SDRAM_SEL) pop(a, rd_exp(a, v) & m, m, 1'b0);
    $display("test transfer at %h done", a);
endtask
task automatic sx(input logic rd, input logic [31:0] a, input logic [63:0] d);
    int k;
    @(negedge clk_in);
    xa = a;
    xd = d;
    read_strobe_n_in = !rd;
    write_low_strobe_n_in = rd;
    write_high_strobe_n_in = rd;
    k = 0;
    if (rd) begin
        while (slv_rd_req_out !== 1'b1 && k < 50) begin
            @(negedge clk_in);
            k++;
        end
        cmp("slave read addr", a, slv_rd_addr_out);
        @(negedge clk_in);
        cmp("slave wait", 0, ack_out);
        slv_rd_valid_in = 1'b1;
        slv_rd_data_in = d;
        @(negedge clk_in);
        slv_rd_valid_in = 1'b0;
        slv_rd_data_in = ~d;
    end
    while (ack_out !== 1'b1 && k < 100) begin
        @(negedge clk_in);
        k++;
    end
    to_chk(k >= 100, "slave ack");
    if (rd) cmp("slave data", {2'b0, d}, {ack_oe_b_out, ext_data_bus_oe_b_out, ext_data_bus_out});
    @(posedge clk_in);
endtask
task automatic idle();
    @(negedge clk_in);
    read_strobe_n_in = 1'b1;
    write_low_strobe_n_in = 1'b1;
    write_high_strobe_n_in = 1'b1;
    burst_indicator_in = 1'b0;
    xa = ~xa;
    xd = ~xd;
    repeat (3) @(negedge clk_in);
endtask
////////////////////////////////////////////////////////////////////////////
initial begin
    {rst_b_in, req_valid_in, slv_rd_valid_in, burst_indicator_in} = 4'h0;
    {width_mem64_in, width_mp64_in, width_host64_in} = 3'h0;
    {read_strobe_n_in, write_low_strobe_n_in, write_high_strobe_n_in} = 3'h7;
    {bus_grant_in, inb_ready_in, boot_memory_select_n_in} = 3'h6;
    {id_in, wt, xa, xd, slv_rd_data_in} = '0;
    req_in = '0;
    repeat (16) @(posedge clk_in);
    @(negedge clk_in);
    rst_b_in = 1'b1;
    repeat (2) @(negedge clk_in);
    cmp("boot strap", 0, rom_boot_mode_out);
    cmp("sdram master", 1, sdram_init_master_out);
    mop(1'b1, SIZE_WORD, 32'h3000_0010, 16'h1);
    mop(1'b1, SIZE_WORD, 32'h2000_0000, 16'h4);
    mop(1'b0, SIZE_QUAD, 32'h1100_0040, 16'h4);
    mop(1'b0, SIZE_LONG, 32'h3800_0008, 16'h2);
    mop(1'b0, SIZE_WORD, 32'h4000_0004, 16'h1);
    r = errs;
    mop(1'b1, SIZE_LONG, 32'h3000_0003, 16'h0);
    cmp("misalign pulse", 1, errs - r);
    {width_mem64_in, width_mp64_in, width_host64_in} = 3'h7;
    mop(1'b1, SIZE_WORD, 32'h3800_0011, 16'h1);
    mop(1'b1, SIZE_LONG, 32'h8000_0020, 16'h1);
    mop(1'b0, SIZE_QUAD, 32'h1100_0040, 16'h2);
    for (int i = 0; i < 24; i++) begin
        r = $random(seed);
        {width_host64_in, width_mem64_in} = r[5:4];
        width_mp64_in = r[4] | r[5] | r[6];
        mop(r[3], {1'b0, r[2]}, (base[r[1:0]] | 32'(r[17:8])) & ~{31'h0, r[2]}, (r[2] && !w64_of(base[r[1:0]])) ? 16'h2 : 16'h1);
    end
    width_mp64_in = 1'b0;
    inbq.delete();
    burst_indicator_in = 1'b1;
    sx(1'b0, 32'h1000_0100, 64'h1234_5678_9ABC_DEF0);
    sx(1'b0, 32'hFFFF_0000, 64'h0FED_CBA9_8765_4321);
    idle();
    pop(32'h1000_0100, 128'h1234_5678_9ABC_DEF0, {64'h0, {64{1'b1}}}, 1'b1);
    pop(32'h1000_0101, 128'h0FED_CBA9_8765_4321, {64'h0, {64{1'b1}}}, 1'b1);
    sx(1'b1, 32'h1000_0208, 64'hA5A5_0000_5A5A_FFFF);
    idle();
    $display("test slave side done");
    print_verdict();
end
endmodule // tb
